// ==== core/dcsi_filter.sv ====
`timescale 1ns/100ps
// hold-time filter: output follows input only after it is stable for hold_cyc cycles
module dcsi_filter
  import dcsi_pkg::*;
#(
  parameter int unsigned HOLD = HOLD_CYC
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic raw_i,
  output logic filt_o
);
  logic [CNT_W-1:0] cnt_ff;
  logic filt_ff;

  // count while the input differs from the accepted level
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_ff <= '0;
      filt_ff <= 1'b0; // open: stop requested until proven closed
    end
    else if (raw_i == filt_ff)
    begin
      cnt_ff <= '0; // short pulse discarded R2
    end
    else if (cnt_ff >= CNT_W'(HOLD - 1))
    begin
      cnt_ff <= '0;
      filt_ff <= raw_i; // R2
    end
    else
    begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign filt_o = filt_ff;
endmodule

// ==== core/dcsi_top.sv ====
`timescale 1ns/100ps
// dual channel stop interlock with wishbone register access
module dcsi_top
  import dcsi_pkg::*;
#(
  parameter int unsigned HOLD = HOLD_CYC
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  // contact inputs: high means contact to return closed
  input wire logic stop_input_one_i,
  input wire logic stop_input_two_i,
  input wire logic power_ok_i,
  input wire logic circuit_fail_i,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // drive and status outputs
  output logic drive_enable_o,
  output logic halt_state_o,
  output logic stop_circuit_ok_o,
  output logic open_collector_output_o,
  output logic halt_indicator_o,
  output logic [7:0] stop_circuit_fault_code_o,
  output logic irq_o
);
  // ----------------------------------------------------------------
  // input filtering
  // ----------------------------------------------------------------
  logic ch1_closed;
  logic ch2_closed;

  dcsi_filter #(.HOLD(HOLD)) u_flt1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raw_i(stop_input_one_i),
    .filt_o(ch1_closed)
  );

  dcsi_filter #(.HOLD(HOLD)) u_flt2 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raw_i(stop_input_two_i),
    .filt_o(ch2_closed)
  );

  // ----------------------------------------------------------------
  // interlock decision
  // ----------------------------------------------------------------
  dcsi_state_e state_ff;
  dcsi_state_e nxt_state;
  logic [7:0] nxt_code;
  logic mismatch;

  assign mismatch = ch1_closed ^ ch2_closed; // R12

  // classify the current situation
  always_comb
  begin
    nxt_code = FAULT_CODE_NONE;
    if (!power_ok_i)
    begin
      nxt_state = DCSI_OFF; // R13
    end
    else if (circuit_fail_i)
    begin
      nxt_state = DCSI_FAULT; // R5
      nxt_code = FAULT_CODE_INTERNAL; // R5
    end
    else if (mismatch)
    begin
      nxt_state = DCSI_FAULT; // R12
      nxt_code = FAULT_CODE_MISMATCH; // R12
    end
    else if (ch1_closed)
    begin
      nxt_state = DCSI_RUN; // R3 R11
    end
    else
    begin
      nxt_state = DCSI_HALT; // R4 R11
    end
  end

  logic [7:0] code_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_ff <= DCSI_OFF;
      code_ff <= FAULT_CODE_NONE;
    end
    else
    begin
      state_ff <= nxt_state;
      code_ff <= nxt_code;
    end
  end

  // ----------------------------------------------------------------
  // outputs: high means transistor conducts
  // ----------------------------------------------------------------
  logic [CTRL_SEL_W-1:0] ctrl_ff;
  logic nxt_enable;
  logic nxt_halt;
  logic nxt_ok;
  logic nxt_oc;

  // status levels per state
  always_comb
  begin
    nxt_enable = 1'b0;
    nxt_halt = 1'b0;
    nxt_ok = 1'b0;
    case (nxt_state)
      DCSI_RUN:
      begin
        nxt_enable = 1'b1; // R3
        nxt_ok = 1'b1; // R3
      end
      DCSI_HALT:
      begin
        nxt_halt = 1'b1; // R4
        nxt_ok = 1'b1; // R4
      end
      default:
      begin
        nxt_enable = 1'b0; // R5 R13
      end
    endcase
    if (ctrl_ff == SEL_CIRCUIT_OK)
    begin
      nxt_oc = nxt_ok; // R7 R6
    end
    else if (ctrl_ff == SEL_HALT)
    begin
      nxt_oc = nxt_halt; // R6
    end
    else
    begin
      nxt_oc = nxt_enable; // running status by default
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      drive_enable_o <= 1'b0;
      halt_state_o <= 1'b0;
      stop_circuit_ok_o <= 1'b0;
      open_collector_output_o <= 1'b0;
      halt_indicator_o <= 1'b0;
      stop_circuit_fault_code_o <= FAULT_CODE_NONE;
    end
    else
    begin
      drive_enable_o <= nxt_enable;
      halt_state_o <= nxt_halt; // R6
      stop_circuit_ok_o <= nxt_ok; // R6
      open_collector_output_o <= nxt_oc; // R7
      halt_indicator_o <= nxt_halt; // R4
      stop_circuit_fault_code_o <= nxt_code; // R5
    end
  end

  // ----------------------------------------------------------------
  // events and interrupt
  // ----------------------------------------------------------------
  logic [EV_W-1:0] evt_ff;
  logic [EV_W-1:0] mask_ff;
  logic [EV_W-1:0] evt_set;
  logic acc;
  logic rd_evt;

  assign acc = cyc_i && stb_i && !ack_o && !err_o;
  assign rd_evt = acc && !we_i && (adr_i == ADDR_EVT);

  // entering halt, fault or run raises its event
  always_comb
  begin
    evt_set = '0;
    evt_set[EV_HALT] = (nxt_state == DCSI_HALT) && (state_ff != DCSI_HALT);
    evt_set[EV_FAULT] = (nxt_state == DCSI_FAULT) && (state_ff != DCSI_FAULT);
    evt_set[EV_ENABLE] = (nxt_state == DCSI_RUN) && (state_ff != DCSI_RUN);
  end

  // sticky events, cleared by read, new events win over the clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      evt_ff <= '0;
    end
    else if (rd_evt)
    begin
      evt_ff <= evt_set;
    end
    else
    begin
      evt_ff <= evt_ff | evt_set;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= |(nxt_evt_irq());
    end
  end

  function automatic logic [EV_W-1:0] nxt_evt_irq();
    logic [EV_W-1:0] v;
    v = rd_evt ? evt_set : (evt_ff | evt_set);
    return v & mask_ff;
  endfunction

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  logic [31:0] nxt_dat;
  logic hit;

  // read mux and address decode
  always_comb
  begin
    nxt_dat = 32'h0000_0000;
    hit = 1'b1;
    if (adr_i == ADDR_CTRL)
    begin
      nxt_dat[CTRL_SEL_W-1:0] = ctrl_ff;
    end
    else if (adr_i == ADDR_STAT)
    begin
      nxt_dat[ST_ENABLE] = drive_enable_o;
      nxt_dat[ST_HALT] = halt_state_o;
      nxt_dat[ST_OK] = stop_circuit_ok_o;
      nxt_dat[ST_FAULT] = (code_ff != FAULT_CODE_NONE); // R5 R12
      nxt_dat[ST_CH1] = ch1_closed;
      nxt_dat[ST_CH2] = ch2_closed;
    end
    else if (adr_i == ADDR_EVT)
    begin
      nxt_dat[EV_W-1:0] = evt_ff;
    end
    else if (adr_i == ADDR_MASK)
    begin
      nxt_dat[EV_W-1:0] = mask_ff;
    end
    else
    begin
      hit = 1'b0;
    end
  end

  // one-cycle answer, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= acc && hit;
      err_o <= acc && !hit;
      dat_o <= (acc && hit && !we_i) ? nxt_dat : 32'h0000_0000;
    end
  end

  // writable registers, low byte lane only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_ff <= CTRL_RST;
      mask_ff <= '0;
    end
    else if (acc && we_i && sel_i[0])
    begin
      if (adr_i == ADDR_CTRL)
      begin
        ctrl_ff <= dat_i[CTRL_SEL_W-1:0];
      end
      else if (adr_i == ADDR_MASK)
      begin
        mask_ff <= dat_i[EV_W-1:0];
      end
    end
  end
endmodule

// ==== shared/dcsi_pkg.sv ====
// Operation
// R1: relay holds each stop contact state at least 2 ms before drive acts.
// R2: input changes shorter than 2 ms are ignored as if absent.
// R3: power, both closed, no failure: drive enabled, halt off, circuit ok on.
// R4: both open, no failure: output off, both status on, halt indicator shown.
// R5: internal failure: output off, both status off, fault code shown.
// R6: asserted status means open-collector transistor conducts.
// R7: select equal to circuit-ok code routes circuit ok onto open-collector terminal.
// R8: relay feeds circuit-ok terminal and its return to its feedback inputs.
// R9: halt status used only for monitoring, never as stop input elsewhere.
// R10: circuit ok used only for alarms or restart blocking, never as stop input.
// R11: open contact means stop requested, closed means no stop.
// R12: channels disagreeing after filtering count as internal circuit failure.
// R13: without input power output stays off and both status outputs off.
package dcsi_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned HOLD_US = 2000;
  localparam int unsigned HOLD_CYC = (HOLD_US * (CLK_HZ / 1_000_000));
  localparam int unsigned CNT_W = 16;

  // wishbone register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_EVT = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0c;

  // ctrl fields
  localparam int unsigned CTRL_SEL_LSB = 0;
  localparam int unsigned CTRL_SEL_W = 8;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] SEL_HALT = 8'h50;
  localparam logic [7:0] SEL_CIRCUIT_OK = 8'h51;

  // status bit positions
  localparam int unsigned ST_ENABLE = 0;
  localparam int unsigned ST_HALT = 1;
  localparam int unsigned ST_OK = 2;
  localparam int unsigned ST_FAULT = 3;
  localparam int unsigned ST_CH1 = 4;
  localparam int unsigned ST_CH2 = 5;

  // event bit positions
  localparam int unsigned EV_W = 3;
  localparam int unsigned EV_HALT = 0;
  localparam int unsigned EV_FAULT = 1;
  localparam int unsigned EV_ENABLE = 2;

  localparam logic [7:0] FAULT_CODE_NONE = 8'h00;
  localparam logic [7:0] FAULT_CODE_MISMATCH = 8'h01;
  localparam logic [7:0] FAULT_CODE_INTERNAL = 8'h02;

  typedef enum logic [1:0] {
    DCSI_OFF,
    DCSI_RUN,
    DCSI_HALT,
    DCSI_FAULT
  } dcsi_state_e;
endpackage

// ==== verif/dcsi_assertions.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// interlock output checks
// ----------------------------------------
module dcsi_checker
  import dcsi_pkg::*;
#(
  parameter int unsigned HOLD = HOLD_CYC
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stop_input_one_i,
  input wire logic stop_input_two_i,
  input wire logic power_ok_i,
  input wire logic circuit_fail_i,
  input wire logic drive_enable_o,
  input wire logic halt_state_o,
  input wire logic stop_circuit_ok_o,
  input wire logic halt_indicator_o,
  input wire logic [7:0] stop_circuit_fault_code_o
);
  wire logic q_bad = !power_ok_i || circuit_fail_i;
  logic [CNT_W-1:0] cl_ff;
  logic [CNT_W-1:0] op_ff;
  logic [CNT_W-1:0] mm_ff;
  // edges each contact pattern has stood unbroken, open and mismatch only while power is ok and no failure is set
  always_ff @(posedge clk_i)
  begin
    cl_ff <= (rst_i || !(stop_input_one_i && stop_input_two_i)) ? '0 : cl_ff + 1'b1;
    op_ff <= (rst_i || q_bad || stop_input_one_i || stop_input_two_i) ? '0 : op_ff + 1'b1;
    mm_ff <= (rst_i || q_bad || stop_input_one_i == stop_input_two_i) ? '0 : mm_ff + 1'b1;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_nopwr;
    !power_ok_i |=> !drive_enable_o && !halt_state_o && !stop_circuit_ok_o;
  endproperty
  a_nopwr: assert property (p_nopwr) else $error("output active without power");
  property p_fail;
    power_ok_i && circuit_fail_i |=> stop_circuit_fault_code_o == FAULT_CODE_INTERNAL;
  endproperty
  a_fail: assert property (p_fail) else $error("failure code missing");
  property p_code;
    stop_circuit_fault_code_o != FAULT_CODE_NONE |-> !drive_enable_o && !stop_circuit_ok_o;
  endproperty
  a_code: assert property (p_code) else $error("fault without shutoff");
  property p_rise;
    $rose(drive_enable_o) |-> cl_ff >= HOLD;
  endproperty
  a_rise: assert property (p_rise) else $error("enable before hold time");
  property p_en;
    drive_enable_o |-> stop_circuit_ok_o && !halt_state_o;
  endproperty
  a_en: assert property (p_en) else $error("run status wrong");
  property p_halt;
    halt_state_o |-> stop_circuit_ok_o && halt_indicator_o && !drive_enable_o;
  endproperty
  a_halt: assert property (p_halt) else $error("halt status wrong");
  property p_open;
    op_ff > HOLD + 1 |-> halt_state_o;
  endproperty
  a_open: assert property (p_open) else $error("open contacts not halting");
  property p_mis;
    mm_ff > HOLD + 1 |-> stop_circuit_fault_code_o == FAULT_CODE_MISMATCH;
  endproperty
  a_mis: assert property (p_mis) else $error("mismatch not faulted");
  c_run: cover property ($rose(drive_enable_o));
  c_halt: cover property ($rose(halt_state_o));
  c_mis: cover property (stop_circuit_fault_code_o == FAULT_CODE_MISMATCH);
endmodule
bind dcsi_top dcsi_checker #(.HOLD(HOLD)) i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .stop_input_one_i(stop_input_one_i), .stop_input_two_i(stop_input_two_i),
  .power_ok_i(power_ok_i), .circuit_fail_i(circuit_fail_i), .drive_enable_o(drive_enable_o),
  .halt_state_o(halt_state_o), .stop_circuit_ok_o(stop_circuit_ok_o),
  .halt_indicator_o(halt_indicator_o), .stop_circuit_fault_code_o(stop_circuit_fault_code_o));

// ==== verif/dcsi_relay_model.sv ====
`timescale 1ns/100ps
// relay stand-in: keeps each contact state long enough, pulses channel one on demand
module dcsi_relay_model
  import dcsi_pkg::*;
#(
  parameter int unsigned HOLD = HOLD_CYC
)
(
  input wire logic clk_i,
  input wire logic [1:0] req_i,
  input wire logic glitch_i,
  input wire logic fb_a_i,
  input wire logic fb_b_i,
  output logic ch1_o,
  output logic ch2_o,
  output logic fb_ok_o
);
  logic [1:0] st_ff = 2'h0;
  int unsigned age_ff = 0;
  // a new contact state is taken only once the old one has stood long enough
  always @(posedge clk_i)
  begin
    if (req_i != st_ff && age_ff >= HOLD)
    begin
      st_ff <= req_i;
      age_ff <= 0;
    end
    else
      age_ff <= age_ff + 1;
  end
  // feedback loop as the relay sees it: terminal conducting against its return
  always @(posedge clk_i)
  begin
    fb_ok_o <= fb_a_i && !fb_b_i;
  end
  // halt status is never taken as a stop input here
  assign ch1_o = st_ff[0] ^ glitch_i;
  assign ch2_o = st_ff[1];
endmodule

// ==== verif/dcsi_top_tb_top.sv ====
`timescale 1ns/100ps
module dcsi_top_tb_top
  import dcsi_pkg::*;
;
  localparam int unsigned HOLD = 20;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic pwr = 1'b0;
  logic fail = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic glitch = 1'b0;
  logic [1:0] req = 2'h0;
  logic [3:0] sel = 4'hf;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic ch1, ch2, ack_o, err_o, en, halt, ok, oc, ind, irq, fb;
  logic [7:0] code;
  logic [31:0] rdat;
  int miscompares = 0;
  int checks = 0;
  always #50 clk_i = ~clk_i;
  dcsi_top #(.HOLD(HOLD)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .stop_input_one_i(ch1),
    .stop_input_two_i(ch2), .power_ok_i(pwr), .circuit_fail_i(fail), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .dat_i(dat), .sel_i(sel), .dat_o(rdat), .ack_o(ack_o),
    .err_o(err_o), .drive_enable_o(en), .halt_state_o(halt), .stop_circuit_ok_o(ok),
    .open_collector_output_o(oc), .halt_indicator_o(ind), .stop_circuit_fault_code_o(code),
    .irq_o(irq));
  dcsi_relay_model #(.HOLD(HOLD)) i_relay (.clk_i(clk_i), .req_i(req), .glitch_i(glitch),
    .fb_a_i(oc), .fb_b_i(1'b0), .ch1_o(ch1), .ch2_o(ch2), .fb_ok_o(fb));
  // ----------------------------------------
  // reporting and bus cycles
  // ----------------------------------------
  task conclude;
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task bad(input string m);
    miscompares++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task chk_out(input logic [4:0] e, input logic [7:0] c);
    checks++;
    if ({en, halt, ok, oc, ind, code} !== {e, c})
      bad("interlock outputs");
  endtask
  task chk_val(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
      bad("bus or irq value");
  endtask
  // classic cycle held until ack or err is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 50)
    begin
      @(posedge clk_i);
      n++;
    end
    q = rdat;
    e = err_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50)
    begin
      bad("bus hang");
      conclude;
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    wb(1'b0, a, 32'h0000_0000, q, e);
    chk_val(q, x);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    wb(1'b1, a, d, q, e);
  endtask
  task settle;
    repeat (2 * HOLD + 6) @(posedge clk_i);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_run;
    rd(ADDR_CTRL, 32'h0000_0000);
    rd(ADDR_MASK, 32'h0000_0000);
    chk_out(5'h00, FAULT_CODE_NONE);
    pwr <= 1'b1;
    req <= 2'h3;
    settle;
    chk_out(5'h16, FAULT_CODE_NONE);
    rd(ADDR_EVT, 32'h0000_0005);
    rd(ADDR_EVT, 32'h0000_0000);
  endtask
  task t_glitch;
    glitch <= 1'b1;
    repeat (HOLD - 3) @(posedge clk_i);
    glitch <= 1'b0;
    repeat (HOLD + 4) @(posedge clk_i);
    chk_out(5'h16, FAULT_CODE_NONE);
    rd(ADDR_EVT, 32'h0000_0000);
  endtask
  task t_halt;
    wr(ADDR_MASK, 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_0050);
    req <= 2'h0;
    settle;
    chk_out(5'h0f, FAULT_CODE_NONE);
    chk_val({31'h0000_0000, irq}, 32'h0000_0001);
    rd(ADDR_EVT, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    chk_val({31'h0000_0000, irq}, 32'h0000_0000);
  endtask
  task t_fault;
    wr(ADDR_CTRL, 32'h0000_0051);
    req <= 2'h3;
    settle;
    chk_out(5'h16, FAULT_CODE_NONE);
    chk_val({31'h0000_0000, irq}, 32'h0000_0000);
    chk_val({31'h0000_0000, fb}, 32'h0000_0001);
    fail <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk_out(5'h00, FAULT_CODE_INTERNAL);
    chk_val({31'h0000_0000, fb}, 32'h0000_0000);
    rd(ADDR_STAT, 32'h0000_0038);
    rd(ADDR_EVT, 32'h0000_0006);
    fail <= 1'b0;
  endtask
  task t_mismatch;
    req <= 2'h1;
    settle;
    chk_out(5'h00, FAULT_CODE_MISMATCH);
  endtask
  task t_nopower;
    req <= 2'h3;
    settle;
    pwr <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk_out(5'h00, FAULT_CODE_NONE);
  endtask
  task t_refuse;
    logic [31:0] q;
    logic e;
    wb(1'b1, 8'h10, 32'h0000_0000, q, e);
    chk_val({31'h0000_0000, e}, 32'h0000_0001);
    sel <= 4'he;
    wr(ADDR_CTRL, 32'h0000_0000);
    sel <= 4'hf;
    rd(ADDR_CTRL, 32'h0000_0051);
  endtask
  // main sequence after a 16-cycle reset
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_run;
    t_glitch;
    t_halt;
    t_fault;
    t_mismatch;
    t_nopower;
    t_refuse;
    conclude;
  end
  // watchdog against a hung run
  initial
  begin
    repeat (3000) @(posedge clk_i);
    bad("run timeout");
    conclude;
  end
endmodule
